// ==== tecf_pkg.sv ====
// constants for the timer and external interrupt control flag block
package tecf_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] CTRL_OFF = 8'h88;
   localparam logic [7:0] IE2_OFF  = 8'h8C;
   localparam logic [7:0] STAT_OFF = 8'h90;
   localparam logic [7:0] MASK_OFF = 8'h94;
   // control register field positions
   localparam int T1_FLAG_BIT = 7;
   localparam int T1_RUN_BIT  = 6;
   localparam int T0_FLAG_BIT = 5;
   localparam int T0_RUN_BIT  = 4;
   localparam int X1_PEND_BIT = 3;
   localparam int X1_TYPE_BIT = 2;
   localparam int X0_PEND_BIT = 1;
   localparam int X0_TYPE_BIT = 0;
   // second enable register field position
   localparam int CEN_BIT = 3;
   // event status layout
   localparam int EV_W      = 5;
   localparam int EV_EXT0   = 0;
   localparam int EV_TMR0   = 1;
   localparam int EV_EXT1   = 2;
   localparam int EV_TMR1   = 3;
   localparam int EV_CARD   = 4;
   // reset values
   localparam logic [7:0]      CTRL_RST = 8'h00;
   localparam logic            CEN_RST  = 1'b0;
   localparam logic [EV_W-1:0] EV_RST   = 5'h00;
   localparam logic [31:0]     DAT_RST  = 32'h0000_0000;
endpackage

// ==== tecf_det_if.sv ====
// carrier between the flag logic and one external pin detector
`timescale 1ns/100ps
`default_nettype none
interface tecf_det_if;
   logic edge_mode;
   logic detect;
   modport ctrl (output edge_mode, input detect);
   modport det  (input edge_mode, output detect);
endinterface
`default_nettype wire

// ==== tecf_extdet.sv ====
// pin synchroniser with level or falling edge detection
`timescale 1ns/100ps
`default_nettype none
module tecf_extdet (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // external pin
   input  wire logic pin_i,
   // towards the flag logic
   tecf_det_if.det   det
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic detect_q;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // low level, or a high to low step when edge mode is chosen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         detect_q <= 1'b0;
      end else if (det.edge_mode) begin
         detect_q <= prev_q & ~sync2_q; // R10
      end else begin
         detect_q <= ~sync2_q; // R10
      end
   end

   assign det.detect = detect_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_edge_pulse: assert property (det.edge_mode && prev_q && !sync2_q |=> det.detect) // R10
      else $error("falling edge not detected");
   chk_edge_quiet: assert property (det.edge_mode && sync2_q |=> !det.detect) // R10
      else $error("edge mode detect without a fall");
   chk_level_follow: assert property (!det.edge_mode |=> det.detect == !$past(sync2_q)) // R10
      else $error("level mode detect does not follow pin");
endmodule
`default_nettype wire

// ==== tecf_flags.sv ====
// timer and external interrupt control flags with wishbone register access
//
// Function
// R1: timer 1 overflow sets its flag, which clears when the core vectors to its routine.
// R2: timer 0 overflow sets its flag, which clears when the core vectors to its routine.
// R3: timer 1 runs while its run bit is one and halts while it is zero.
// R4: an interrupt condition on external input 0 sets its pending flag.
// R5: external input 0 pending clears on service only when edge triggered.
// R6: after reset the control register is all zero.
// R7: after reset the card interrupt enable bit is zero.
// R8: reserved bits are not stored and read back as zero; software writes no ones there.
// R9: an interrupt on external input 1 sets its pending flag, which clears when processed.
// R10: the type bit of input 1 chooses level or falling edge triggering.
// R11: timer 0 runs while its run bit is one and halts while it is zero.
// R12: a card interface request reaches the core only while its enable bit is one; irq_o takes card_irq_i through the EV_CARD status bit without the enable.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tecf_flags (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   // timers
   input  wire logic        timer0_overflow_i,
   input  wire logic        timer1_overflow_i,
   output var  logic        timer0_run_o,
   output var  logic        timer1_run_o,
   // core vectoring acknowledges
   input  wire logic        timer0_vector_i,
   input  wire logic        timer1_vector_i,
   input  wire logic        ext0_vector_i,
   input  wire logic        ext1_vector_i,
   // external pins
   input  wire logic        ext_irq0_pin_i,
   input  wire logic        ext_irq1_pin_i,
   // card interface request
   input  wire logic        card_irq_i,
   // towards the prioritizer
   output var  logic        timer0_overflow_flag_o,
   output var  logic        timer1_overflow_flag_o,
   output var  logic        ext_irq0_pending_o,
   output var  logic        ext_irq1_pending_o,
   output var  logic        card_irq_req_o,
   // summary interrupt
   output var  logic        irq_o
);
   logic                       ack_q;
   logic [31:0]                dat_q;
   logic [31:0]                rd_d;
   logic                       t1_flag_q;
   logic                       t1_run_q;
   logic                       t0_flag_q;
   logic                       t0_run_q;
   logic                       ie1p_q;
   logic                       x1_type_q;
   logic                       ie0p_q;
   logic                       it0_q;
   logic                       card_en_q;
   logic                       card_req_q;
   logic [tecf_pkg::EV_W-1:0]  stat_q;
   logic [tecf_pkg::EV_W-1:0]  mask_q;
   logic [tecf_pkg::EV_W-1:0]  events;
   logic                       irq_q;
   logic [7:0]                 ctrl_rd;
   logic [1:0]                 pins;
   logic [1:0]                 det_w;
   logic [1:0]                 types;
   logic                       req;
   logic                       wr_hit;
   logic                       wr_ctrl;
   logic                       wr_ie2;
   logic                       wr_stat;
   logic                       wr_mask;

   ////////////////////////////////////////////////////////////////////////////
   // pin detectors
   assign pins  = {ext_irq1_pin_i, ext_irq0_pin_i};
   assign types = {x1_type_q, it0_q};

   tecf_det_if det_bus [2] ();

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_det
         assign det_bus[g].edge_mode = types[g]; // R10
         assign det_w[g]             = det_bus[g].detect;
         tecf_extdet u_det (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .pin_i (pins[g]),
            .det   (det_bus[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // bus decode, one wait state, write lands on the ack edge
   assign req     = wb_cyc_i & wb_stb_i;
   assign wr_hit  = req & ack_q & wb_we_i & wb_sel_i[0];
   assign wr_ctrl = wr_hit && (wb_adr_i == tecf_pkg::CTRL_OFF);
   assign wr_ie2  = wr_hit && (wb_adr_i == tecf_pkg::IE2_OFF);
   assign wr_stat = wr_hit && (wb_adr_i == tecf_pkg::STAT_OFF);
   assign wr_mask = wr_hit && (wb_adr_i == tecf_pkg::MASK_OFF);

   assign ctrl_rd = {t1_flag_q, t1_run_q, t0_flag_q, t0_run_q, ie1p_q, x1_type_q, ie0p_q, it0_q};

   always_comb begin
      rd_d = tecf_pkg::DAT_RST;
      case (wb_adr_i)
         tecf_pkg::CTRL_OFF: rd_d[7:0] = ctrl_rd;
         tecf_pkg::IE2_OFF:  rd_d[tecf_pkg::CEN_BIT] = card_en_q; // R8
         tecf_pkg::STAT_OFF: rd_d[tecf_pkg::EV_W-1:0] = stat_q;
         tecf_pkg::MASK_OFF: rd_d[tecf_pkg::EV_W-1:0] = mask_q;
         default:            rd_d = tecf_pkg::DAT_RST;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= tecf_pkg::DAT_RST;
      end else if (req & ~ack_q & ~wb_we_i) begin
         dat_q <= rd_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // timer overflow flags: set beats write beats vector clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_flag_q <= tecf_pkg::CTRL_RST[tecf_pkg::T1_FLAG_BIT]; // R6
      end else if (timer1_overflow_i) begin
         t1_flag_q <= 1'b1; // R1
      end else if (wr_ctrl) begin
         t1_flag_q <= wb_dat_i[tecf_pkg::T1_FLAG_BIT];
      end else if (timer1_vector_i) begin
         t1_flag_q <= 1'b0; // R1
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t0_flag_q <= tecf_pkg::CTRL_RST[tecf_pkg::T0_FLAG_BIT]; // R6
      end else if (timer0_overflow_i) begin
         t0_flag_q <= 1'b1; // R2
      end else if (wr_ctrl) begin
         t0_flag_q <= wb_dat_i[tecf_pkg::T0_FLAG_BIT];
      end else if (timer0_vector_i) begin
         t0_flag_q <= 1'b0; // R2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run controls and trigger types
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_run_q  <= tecf_pkg::CTRL_RST[tecf_pkg::T1_RUN_BIT]; // R6
         t0_run_q  <= tecf_pkg::CTRL_RST[tecf_pkg::T0_RUN_BIT]; // R6
         x1_type_q <= tecf_pkg::CTRL_RST[tecf_pkg::X1_TYPE_BIT]; // R6
         it0_q     <= tecf_pkg::CTRL_RST[tecf_pkg::X0_TYPE_BIT]; // R6
      end else if (wr_ctrl) begin
         t1_run_q  <= wb_dat_i[tecf_pkg::T1_RUN_BIT]; // R3
         t0_run_q  <= wb_dat_i[tecf_pkg::T0_RUN_BIT]; // R11
         x1_type_q <= wb_dat_i[tecf_pkg::X1_TYPE_BIT]; // R10
         it0_q     <= wb_dat_i[tecf_pkg::X0_TYPE_BIT];
      end
   end

   assign timer1_run_o = t1_run_q; // R3
   assign timer0_run_o = t0_run_q; // R11

   ////////////////////////////////////////////////////////////////////////////
   // external input 0: level mode mirrors the pin, edge mode is sticky
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ie0p_q <= tecf_pkg::CTRL_RST[tecf_pkg::X0_PEND_BIT]; // R6
      end else if (!it0_q) begin
         ie0p_q <= det_w[0]; // R4
      end else if (det_w[0]) begin
         ie0p_q <= 1'b1; // R4
      end else if (wr_ctrl) begin
         ie0p_q <= wb_dat_i[tecf_pkg::X0_PEND_BIT];
      end else if (ext0_vector_i) begin
         ie0p_q <= 1'b0; // R5
      end
   end

   // external input 1: cleared when processed in either mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ie1p_q <= tecf_pkg::CTRL_RST[tecf_pkg::X1_PEND_BIT]; // R6
      end else if (det_w[1]) begin
         ie1p_q <= 1'b1; // R9
      end else if (wr_ctrl) begin
         ie1p_q <= wb_dat_i[tecf_pkg::X1_PEND_BIT];
      end else if (ext1_vector_i) begin
         ie1p_q <= 1'b0; // R9
      end
   end

   assign timer0_overflow_flag_o = t0_flag_q;
   assign timer1_overflow_flag_o = t1_flag_q;
   assign ext_irq0_pending_o     = ie0p_q;
   assign ext_irq1_pending_o     = ie1p_q;

   ////////////////////////////////////////////////////////////////////////////
   // card interface enable and gated request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         card_en_q <= tecf_pkg::CEN_RST; // R7
      end else if (wr_ie2) begin
         card_en_q <= wb_dat_i[tecf_pkg::CEN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         card_req_q <= 1'b0;
      end else begin
         card_req_q <= card_irq_i & card_en_q; // R12
      end
   end

   assign card_irq_req_o = card_req_q;

   ////////////////////////////////////////////////////////////////////////////
   // sticky event status, write one to clear, new event wins
   always_comb begin
      events                    = tecf_pkg::EV_RST;
      events[tecf_pkg::EV_EXT0] = det_w[0];
      events[tecf_pkg::EV_TMR0] = timer0_overflow_i;
      events[tecf_pkg::EV_EXT1] = det_w[1];
      events[tecf_pkg::EV_TMR1] = timer1_overflow_i;
      events[tecf_pkg::EV_CARD] = card_irq_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= tecf_pkg::EV_RST;
      end else if (wr_stat) begin
         stat_q <= (stat_q & ~wb_dat_i[tecf_pkg::EV_W-1:0]) | events;
      end else begin
         stat_q <= stat_q | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= tecf_pkg::EV_RST;
      end else if (wr_mask) begin
         mask_q <= wb_dat_i[tecf_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign irq_o = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_ie2_read;
      req && !ack_q && !wb_we_i && (wb_adr_i == tecf_pkg::IE2_OFF) ##1 ack_q;
   endsequence

   sequence s_ext0_serviced;
      it0_q && ext0_vector_i && !det_w[0] && !wr_ctrl;
   endsequence

   sequence s_card_allowed;
      card_irq_i && card_en_q;
   endsequence

   chk_t1_flag_set: assert property (timer1_overflow_i |=> timer1_overflow_flag_o) // R1
      else $error("timer 1 overflow flag not set");
   chk_t1_flag_clear: assert property (timer1_vector_i && !timer1_overflow_i && !wr_ctrl // R1
                                       |=> !timer1_overflow_flag_o)
      else $error("timer 1 overflow flag not cleared by vector");
   chk_t0_flag_set: assert property (timer0_overflow_i |=> timer0_overflow_flag_o) // R2
      else $error("timer 0 overflow flag not set");
   chk_t0_flag_clear: assert property (timer0_vector_i && !timer0_overflow_i && !wr_ctrl // R2
                                       |=> !timer0_overflow_flag_o)
      else $error("timer 0 overflow flag not cleared by vector");
   chk_t1_run_write: assert property (wr_ctrl |=> timer1_run_o == $past(wb_dat_i[tecf_pkg::T1_RUN_BIT])) // R3
      else $error("timer 1 run does not follow write");
   chk_t1_run_hold: assert property (!wr_ctrl |=> $stable(timer1_run_o)) // R3
      else $error("timer 1 run changed without write");
   chk_t0_run_write: assert property (wr_ctrl |=> timer0_run_o == $past(wb_dat_i[tecf_pkg::T0_RUN_BIT])) // R11
      else $error("timer 0 run does not follow write");
   chk_ext0_set: assert property (det_w[0] |=> ext_irq0_pending_o) // R4
      else $error("external 0 pending not set");
   chk_ext0_edge_clear: assert property (s_ext0_serviced |=> !ext_irq0_pending_o) // R5
      else $error("edge external 0 pending not cleared on service");
   chk_ext0_level_keep: assert property (!it0_q && ext0_vector_i && det_w[0] |=> ext_irq0_pending_o) // R5
      else $error("level external 0 pending cleared by service");
   chk_ctrl_reset: assert property (disable iff (1'b0) rst_i |=> ctrl_rd == tecf_pkg::CTRL_RST) // R6
      else $error("control register not zero after reset");
   chk_card_en_reset: assert property (disable iff (1'b0) rst_i |=> !card_en_q) // R7
      else $error("card enable not zero after reset");
   chk_resv_read_zero: assert property (s_ie2_read |-> wb_dat_o[7:4] == 4'h0 && wb_dat_o[2:0] == 3'h0) // R8
      else $error("reserved bits read nonzero");
   chk_ext1_set: assert property (det_w[1] |=> ext_irq1_pending_o) // R9
      else $error("external 1 pending not set");
   chk_ext1_clear: assert property (ext1_vector_i && !det_w[1] && !wr_ctrl |=> !ext_irq1_pending_o) // R9
      else $error("external 1 pending not cleared when processed");
   chk_card_fwd: assert property (s_card_allowed |=> card_irq_req_o) // R12
      else $error("enabled card request not forwarded");
   chk_card_block: assert property (!card_en_q |=> !card_irq_req_o) // R12
      else $error("card request forwarded while disabled");
   chk_irq_level: assert property (|(stat_q & mask_q) |=> irq_o)
      else $error("interrupt output not raised");
endmodule
`default_nettype wire

// ==== tecf_core_model.sv ====
// partner model: two timers and the core's interrupt vectoring
`timescale 1ns/100ps
`default_nettype none
module tecf_core_model #(
   parameter int PERIOD = 8
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // timers
   input  wire logic [1:0] run_i,
   output var  logic [1:0] ovf_o,
   // vectoring: timer0, timer1, ext0, ext1
   input  wire logic [3:0] flag_i,
   input  wire logic [3:0] vec_en_i,
   output var  logic [3:0] vec_o
);
   int cnt_q [2];
   int hold_q [4];
   ////////////////////////////////////////////////////////////////
   // counters advance only while run is high
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         ovf_o[i] <= 1'b0;
         if (rst_i) begin
            cnt_q[i] <= 0;
         end else if (run_i[i]) begin
            cnt_q[i] <= (cnt_q[i] == PERIOD - 1) ? 0 : cnt_q[i] + 1;
            ovf_o[i] <= (cnt_q[i] == PERIOD - 1);
         end
      end
   end
   // vector while a flag stands, then a short routine before the next
   always_ff @(posedge clk_i) begin
      for (int j = 0; j < 4; j++) begin
         vec_o[j] <= 1'b0;
         if (rst_i) begin
            hold_q[j] <= 0;
         end else if (hold_q[j] > 0) begin
            hold_q[j] <= hold_q[j] - 1;
         end else if (flag_i[j] && vec_en_i[j]) begin
            vec_o[j]  <= 1'b1;
            hold_q[j] <= 4;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tecf_flags_tb.sv ====
// self-checking bench for the control flag block
`timescale 1ns/100ps
`default_nettype none
module tecf_flags_tb;
   localparam int PER = 8;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic        ack, card = 1'b0, irq, req;
   logic [1:0]  pin = 2'b11, run, ovf, flg_t, pnd;
   logic [3:0]  vec, ven = 4'h0;
   int          num_errors = 0, n_tests = 0;
   always #5 clk_i = ~clk_i;
   tecf_flags dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .timer0_overflow_i(ovf[0]), .timer1_overflow_i(ovf[1]), .timer0_run_o(run[0]), .timer1_run_o(run[1]),
      .timer0_vector_i(vec[0]), .timer1_vector_i(vec[1]), .ext0_vector_i(vec[2]), .ext1_vector_i(vec[3]),
      .ext_irq0_pin_i(pin[0]), .ext_irq1_pin_i(pin[1]), .card_irq_i(card),
      .timer0_overflow_flag_o(flg_t[0]), .timer1_overflow_flag_o(flg_t[1]),
      .ext_irq0_pending_o(pnd[0]), .ext_irq1_pending_o(pnd[1]), .card_irq_req_o(req), .irq_o(irq));
   tecf_core_model #(.PERIOD(PER)) core_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .ovf_o(ovf),
      .flag_i({pnd[1], pnd[0], flg_t}), .vec_en_i(ven), .vec_o(vec));
   ////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; waits for ack, takes data at that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      step(4);
      bus(0, tecf_pkg::CTRL_OFF, 0); chk(rdat, 32'h00);
      chk({run, flg_t, pnd}, 6'h00);
      bus(0, tecf_pkg::IE2_OFF, 0); chk(rdat & 32'h08, 32'h00);
      $display("reset test done");
      for (int i = 0; i < 2; i++) begin
         int rb, fb;
         rb = i ? tecf_pkg::T1_RUN_BIT : tecf_pkg::T0_RUN_BIT;
         fb = i ? tecf_pkg::T1_FLAG_BIT : tecf_pkg::T0_FLAG_BIT;
         bus(1, tecf_pkg::CTRL_OFF, 32'h1 << rb);
         step(1); chk(run[i], 1'b1);
         step(PER + 2); chk(flg_t[i], 1'b1);
         bus(0, tecf_pkg::CTRL_OFF, 0); chk(rdat, (32'h1 << rb) | (32'h1 << fb));
         bus(1, tecf_pkg::CTRL_OFF, 32'h1 << fb);
         step(1); chk(run[i], 1'b0);
         chk(flg_t[i], 1'b1);
         @(posedge clk_i);
         ven[i] <= 1'b1;
         step(4); chk(flg_t[i], 1'b0);
         @(posedge clk_i);
         ven[i] <= 1'b0;
         step(2 * PER); chk(flg_t[i], 1'b0);
      end
      $display("timer test done");
      for (int k = 0; k < 2; k++) begin
         for (int m = 1; m >= 0; m--) begin
            bus(1, tecf_pkg::CTRL_OFF, m << (2 * k));
            pin[k] <= 1'b0;
            step(8); chk(pnd[k], 1'b1);
            @(posedge clk_i);
            ven[2 + k] <= 1'b1;
            step(4); chk(pnd[k], (m == 0));
            @(posedge clk_i);
            pin[k] <= 1'b1;
            step(10); chk(pnd[k], 1'b0);
            @(posedge clk_i);
            ven[2 + k] <= 1'b0;
         end
      end
      $display("external input test done");
      bus(1, tecf_pkg::IE2_OFF, 32'h08);
      card <= 1'b1;
      step(2); chk(req, 1'b1);
      bus(0, tecf_pkg::IE2_OFF, 0); chk(rdat, 32'h08);
      bus(1, tecf_pkg::IE2_OFF, 32'h00);
      step(2); chk(req, 1'b0);
      @(posedge clk_i);
      card <= 1'b0;
      bus(0, 8'hA0, 0); chk(rdat, 32'h00);
      $display("card enable test done");
      bus(1, tecf_pkg::STAT_OFF, 32'h1F);
      bus(0, tecf_pkg::STAT_OFF, 0); chk(rdat, 32'h00);
      bus(1, tecf_pkg::MASK_OFF, 32'h08);
      bus(1, tecf_pkg::CTRL_OFF, 32'h1 << tecf_pkg::T1_RUN_BIT);
      step(PER + 3); chk(irq, 1'b1);
      bus(1, tecf_pkg::CTRL_OFF, 32'h00);
      bus(0, tecf_pkg::STAT_OFF, 0); chk(rdat, 32'h08);
      bus(1, tecf_pkg::MASK_OFF, 32'h00);
      step(2); chk(irq, 1'b0);
      bus(1, tecf_pkg::MASK_OFF, 32'h08);
      step(2); chk(irq, 1'b1);
      bus(1, tecf_pkg::STAT_OFF, 32'h08);
      step(2); chk(irq, 1'b0);
      $display("interrupt test done");
      bus(1, tecf_pkg::CTRL_OFF, 32'h55);
      bus(1, tecf_pkg::IE2_OFF, 32'h08);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, tecf_pkg::CTRL_OFF, 0); chk(rdat, 32'h00);
      chk({run, flg_t, pnd}, 6'h00);
      bus(0, tecf_pkg::IE2_OFF, 0); chk(rdat, 32'h00);
      $display("second reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
